// [rtl/fl_regs.svh]
`ifndef FL_REGS_SVH
`define FL_REGS_SVH

// Byte offsets of the APB registers
`define A_UPPER      8'h00
`define A_LOWER      8'h04
`define A_HS_UPPER   8'h08
`define A_START      8'h0c
`define A_JOG        8'h10
`define A_BAND0      8'h14
`define A_BAND5      8'h28
`define A_BASE_F     8'h2c
`define A_BASE_V     8'h30
`define A_BASE_F2    8'h34
`define A_TERM       8'h38
`define A_MOT_V      8'h3c
`define A_MOT_F      8'h40
`define A_CTRL       8'h44
`define A_UGRS       8'h48
`define A_FCMD       8'h4c
`define A_TARGET     8'h50
`define A_VOLT       8'h54
`define A_KNEE       8'h58

// Control register fields
`define CTRL_RUN     0
`define CTRL_VEC     1
`define CTRL_ACC_LO  2
`define CTRL_LOAD_LO 4

// Frequencies in 0.1 Hz, voltages in 1 V
`define F_120        16'h04b0
`define F_400        16'h0fa0
`define F_50         16'h01f4
`define V_1000       16'h03e8
`define CODE_OFF     16'h270f
`define CODE_95PCT   16'h22b8
`define TERM_RT_CODE 4'h3
`define ACC_S_A      2'h1
`define LOAD_SQUARE  2'h1

`endif

// [rtl/fl_pkg.sv]
package fl_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] hs_upper;
      logic [15:0] start;
      logic [15:0] jog;
      logic [5:0][15:0] band;
      logic [15:0] base_f;
      logic [15:0] base_v;
      logic [15:0] base_f2;
      logic [6:0][3:0] term;
      logic [15:0] mot_v;
      logic [15:0] mot_f;
      logic [15:0] ugrs;
      logic run;
      logic vec_mode;
      logic [1:0] accel_pat;
      logic [1:0] load_pat;
      logic [15:0] freq_cmd;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [15:0] target;
      logic [15:0] volt;
      logic [15:0] knee;
      logic rt;
   } state_s;

endpackage

// [rtl/band_jump.sv]
`timescale 1ns/1ps
`include "fl_regs.svh"
// Moves a frequency that falls inside an enabled band onto that band's A point
module band_jump #(
   parameter int BANDS = 3
) (
   input wire logic [15:0] freq,
   input wire logic [2*BANDS-1:0][15:0] band,
   output logic [15:0] jumped
);
   logic [BANDS-1:0] hit;

   if (BANDS < 1) begin : g_bad_bands
      $error("band_jump needs at least one band");
   end

   for (genvar i = 0; i < BANDS; i++) begin : g_band
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] lo;
      logic [15:0] hi;
      assign a = band[2*i];
      assign b = band[2*i+1];
      assign lo = (a < b) ? a : b;
      assign hi = (a < b) ? b : a;
      assign hit[i] = (a != `CODE_OFF) && (b != `CODE_OFF) && (freq >= lo) && (freq <= hi);
   end

   always_comb begin
      jumped = freq;
      for (int i = BANDS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            jumped = band[2*i];
         end
      end
   end
endmodule

// [rtl/vf_calc.sv]
`timescale 1ns/1ps
// Output voltage from frequency along a linear or square curve up to the base point
module vf_calc (
   input wire logic [15:0] freq,
   input wire logic [15:0] fbase,
   input wire logic [15:0] vbase,
   input wire logic square,
   output logic [15:0] volt
);
   logic [31:0] lin;
   logic [63:0] sq;

   always_comb begin
      lin = 32'h0;
      sq = 64'h0;
      if (fbase == 16'h0 || freq >= fbase) begin
         volt = vbase;
      end else if (square) begin
         sq = ({48'h0, vbase} * {48'h0, freq} * {48'h0, freq}) / ({48'h0, fbase} * {48'h0, fbase});
         volt = sq[15:0];
      end else begin
         lin = ({16'h0, vbase} * {16'h0, freq}) / {16'h0, fbase};
         volt = lin[15:0];
      end
   end
endmodule

// [rtl/freq_limit_vf.sv]
// What this block does
// - Upper limit, reset 120 Hz, range 0-120
// - Command above upper limit is clamped
// - High-speed upper limit, reset 120, 120-400
// - Writing high-speed limit also sets upper
// - Lower limit, reset 0 Hz, range 0-120
// - Command below lower limit is raised
// - Jog at or below lower wins
// - Run alone ramps to lower limit
// - Three bands, 0-400 Hz, 9999 disables
// - Command inside band runs at A
// - Ramping frequency passes through bands
// - Base frequency, reset 50 Hz, 0-400
// - Base voltage 0-1000, 8888=95%, 9999=supply
// - Base voltage below supply caps output
// - Second base frequency while second function
// - Second function needs terminal code 3
// - Vector mode uses motor rated values
// - S-curve A knee is active base
// - Output voltage never exceeds supply
// - Bands accessible only when read select 0
// - Load pattern 0 gives linear V/F
// - Load pattern 1 gives square V/F outside vector mode
`timescale 1ns/1ps
`include "fl_regs.svh"
module freq_limit_vf (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [6:0] input_terminals,
   input wire logic jog_active,
   input wire logic [15:0] running_freq,
   input wire logic [15:0] supply_voltage,
   output logic [15:0] target_freq,
   output logic [15:0] output_voltage,
   output logic [15:0] s_curve_knee,
   output logic second_function_active
);
   fl_pkg::state_s s_ff;
   fl_pkg::state_s nxt_s;
   fl_pkg::apb_req_s req;
   logic [15:0] jumped;
   logic [15:0] volt_curve;
   logic [15:0] cmd;
   logic [15:0] lo_eff;
   logic [15:0] clamped;
   logic [15:0] fbase;
   logic [15:0] vbase;
   logic [15:0] vcap;
   logic [31:0] v95;
   logic [6:0] rt_hit;
   logic access;
   logic is_band;
   logic [15:0] wv;
   logic bad;
   logic [31:0] rd;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
   assign access = req.psel && req.penable && !s_ff.pready;
   assign is_band = (req.paddr >= `A_BAND0) && (req.paddr <= `A_BAND5);
   assign wv = req.pwdata[15:0];

   for (genvar t = 0; t < 7; t++) begin : g_term
      assign rt_hit[t] = (s_ff.term[t] == `TERM_RT_CODE) && input_terminals[t];
   end

   // Frequency path works on the steady command; ramping frequency is never jumped
   assign cmd = jog_active ? s_ff.jog : s_ff.freq_cmd;

   band_jump #(.BANDS(3)) u_jump (
      .freq(cmd),
      .band(s_ff.band),
      .jumped(jumped)
   );

   always_comb begin
      lo_eff = s_ff.lower;
      if (jog_active && s_ff.jog <= s_ff.lower) begin
         lo_eff = 16'h0;
      end
      clamped = jumped;
      if (clamped < lo_eff) begin
         clamped = lo_eff;
      end
      if (clamped > s_ff.upper) begin
         clamped = s_ff.upper;
      end
   end

   always_comb begin
      v95 = ({16'h0, supply_voltage} * 32'h5f) / 32'h64;
      if (s_ff.vec_mode) begin
         fbase = s_ff.mot_f;
         vbase = s_ff.mot_v;
      end else begin
         fbase = (s_ff.rt && s_ff.base_f2 != `CODE_OFF) ? s_ff.base_f2 : s_ff.base_f;
         if (s_ff.base_v == `CODE_95PCT) begin
            vbase = v95[15:0];
         end else if (s_ff.base_v == `CODE_OFF) begin
            vbase = supply_voltage;
         end else begin
            vbase = s_ff.base_v;
         end
      end
      vcap = (vbase > supply_voltage) ? supply_voltage : vbase;
   end

   // Voltage follows the actual running frequency, bands included while ramping
   vf_calc u_vf (
      .freq(running_freq),
      .fbase(fbase),
      .vbase(vcap),
      .square(!s_ff.vec_mode && s_ff.load_pat == `LOAD_SQUARE),
      .volt(volt_curve)
   );

   always_comb begin
      rd = 32'h0;
      bad = 1'b0;
      case (req.paddr)
         `A_UPPER: rd = {16'h0, s_ff.upper};
         `A_LOWER: rd = {16'h0, s_ff.lower};
         `A_HS_UPPER: rd = {16'h0, s_ff.hs_upper};
         `A_START: rd = {16'h0, s_ff.start};
         `A_JOG: rd = {16'h0, s_ff.jog};
         `A_BASE_F: rd = {16'h0, s_ff.base_f};
         `A_BASE_V: rd = {16'h0, s_ff.base_v};
         `A_BASE_F2: rd = {16'h0, s_ff.base_f2};
         `A_TERM: rd = {4'h0, s_ff.term};
         `A_MOT_V: rd = {16'h0, s_ff.mot_v};
         `A_MOT_F: rd = {16'h0, s_ff.mot_f};
         `A_CTRL: rd = {26'h0, s_ff.load_pat, s_ff.accel_pat, s_ff.vec_mode, s_ff.run};
         `A_UGRS: rd = {16'h0, s_ff.ugrs};
         `A_FCMD: rd = {16'h0, s_ff.freq_cmd};
         `A_TARGET: rd = {16'h0, s_ff.target};
         `A_VOLT: rd = {16'h0, s_ff.volt};
         `A_KNEE: rd = {16'h0, s_ff.knee};
         default: begin
            if (is_band && req.paddr[1:0] == 2'h0 && s_ff.ugrs == 16'h0) begin
               rd = {16'h0, s_ff.band[3'((req.paddr - `A_BAND0) >> 2)]};
            end else begin
               bad = 1'b1;
            end
         end
      endcase
      if (req.pwrite && !bad) begin
         case (req.paddr)
            `A_UPPER, `A_LOWER: bad = (wv > `F_120);
            `A_HS_UPPER: bad = (wv < `F_120) || (wv > `F_400);
            `A_BASE_F, `A_MOT_F: bad = (wv > `F_400);
            `A_BASE_F2: bad = (wv > `F_400) && (wv != `CODE_OFF);
            `A_BASE_V: bad = (wv > `V_1000) && (wv != `CODE_95PCT) && (wv != `CODE_OFF);
            `A_TARGET, `A_VOLT, `A_KNEE: bad = 1'b1;
            default: bad = is_band && (wv > `F_400) && (wv != `CODE_OFF);
         endcase
      end
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.pready = access;
      if (access) begin
         nxt_s.pslverr = bad;
         nxt_s.prdata = req.pwrite ? 32'h0 : rd;
      end
      if (req.psel && req.penable && s_ff.pready && req.pwrite && !s_ff.pslverr) begin
         case (req.paddr)
            `A_UPPER: nxt_s.upper = wv;
            `A_LOWER: nxt_s.lower = wv;
            `A_HS_UPPER: begin
               nxt_s.hs_upper = wv;
               nxt_s.upper = wv;
            end
            `A_START: nxt_s.start = wv;
            `A_JOG: nxt_s.jog = wv;
            `A_BASE_F: nxt_s.base_f = wv;
            `A_BASE_V: nxt_s.base_v = wv;
            `A_BASE_F2: nxt_s.base_f2 = wv;
            `A_TERM: nxt_s.term = req.pwdata[27:0];
            `A_MOT_V: nxt_s.mot_v = wv;
            `A_MOT_F: nxt_s.mot_f = wv;
            `A_CTRL: begin
               nxt_s.run = req.pwdata[`CTRL_RUN];
               nxt_s.vec_mode = req.pwdata[`CTRL_VEC];
               nxt_s.accel_pat = req.pwdata[`CTRL_ACC_LO+:2];
               nxt_s.load_pat = req.pwdata[`CTRL_LOAD_LO+:2];
            end
            `A_UGRS: nxt_s.ugrs = wv;
            `A_FCMD: nxt_s.freq_cmd = wv;
            default: begin
               if (is_band) begin
                  nxt_s.band[3'((req.paddr - `A_BAND0) >> 2)] = wv;
               end
            end
         endcase
      end
      nxt_s.rt = |rt_hit;
      nxt_s.target = (s_ff.run || jog_active) ? clamped : 16'h0;
      nxt_s.volt = volt_curve;
      nxt_s.knee = (s_ff.accel_pat == `ACC_S_A) ? fbase : 16'h0;
      if (sys_rst) begin
         nxt_s = '0;
         nxt_s.upper = `F_120;
         nxt_s.hs_upper = `F_120;
         nxt_s.band = {6{`CODE_OFF}};
         nxt_s.base_f = `F_50;
         nxt_s.base_v = `CODE_95PCT;
         nxt_s.base_f2 = `CODE_OFF;
      end
   end

   always_ff @(posedge clock) begin
      s_ff <= nxt_s;
   end

   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign target_freq = s_ff.target;
   assign output_voltage = s_ff.volt;
   assign s_curve_knee = s_ff.knee;
   assign second_function_active = s_ff.rt;

   property p_upper_clamp;
      @(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) |-> target_freq <= $past(s_ff.upper);
   endproperty
   a_upper_clamp: assert property (p_upper_clamp) else $error("target above upper limit");

   property p_lower_clamp;
      @(posedge clock) disable iff (sys_rst)
      $past(s_ff.run) && !$past(jog_active) && !$past(sys_rst) && $past(s_ff.lower) <= $past(s_ff.upper)
         |-> target_freq >= $past(s_ff.lower);
   endproperty
   a_lower_clamp: assert property (p_lower_clamp) else $error("target below lower limit");

   property p_hs_copy;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && pready && pwrite && !pslverr && paddr == `A_HS_UPPER |=> s_ff.upper == $past(pwdata[15:0]);
   endproperty
   a_hs_copy: assert property (p_hs_copy) else $error("high-speed write did not copy upper");

   property p_upper_range;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && !pready && pwrite && paddr == `A_UPPER && pwdata[15:0] > `F_120 ##1 pready
         ##1 1'b1 |-> s_ff.upper == $past(s_ff.upper, 2);
   endproperty
   a_upper_range: assert property (p_upper_range) else $error("out-of-range upper accepted");

   property p_volt_cap;
      @(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) |-> output_voltage <= $past(supply_voltage);
   endproperty
   a_volt_cap: assert property (p_volt_cap) else $error("voltage above supply");

   property p_knee;
      @(posedge clock) disable iff (sys_rst)
      s_ff.accel_pat == `ACC_S_A && !s_ff.vec_mode && !s_ff.rt |=> s_curve_knee == $past(s_ff.base_f);
   endproperty
   a_knee: assert property (p_knee) else $error("knee not at base frequency");

   property p_band_lock;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && !pready && is_band && s_ff.ugrs != 16'h0 |=> pready && pslverr;
   endproperty
   a_band_lock: assert property (p_band_lock) else $error("band access allowed while locked");

   property p_stop;
      @(posedge clock) disable iff (sys_rst)
      !s_ff.run && !jog_active |=> target_freq == 16'h0;
   endproperty
   a_stop: assert property (p_stop) else $error("target nonzero while stopped");

   property p_answer;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_answer: assert property (p_answer) else $error("APB answer not one cycle");

   property p_idle_ready;
      @(posedge clock) disable iff (sys_rst)
      !psel |=> !pready;
   endproperty
   a_idle_ready: assert property (p_idle_ready) else $error("ready without a request");

   property p_refused_keep;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && pready && pslverr |=> s_ff.band == $past(s_ff.band) && s_ff.upper == $past(s_ff.upper);
   endproperty
   a_refused_keep: assert property (p_refused_keep) else $error("refused write changed a setting");

   property p_hs_range;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && !pready && pwrite && paddr == `A_HS_UPPER
         && (pwdata[15:0] < `F_120 || pwdata[15:0] > `F_400) |=> pready && pslverr;
   endproperty
   a_hs_range: assert property (p_hs_range) else $error("out-of-range high-speed limit accepted");

   property p_lower_range;
      @(posedge clock) disable iff (sys_rst)
      psel && penable && !pready && pwrite && paddr == `A_LOWER && pwdata[15:0] > `F_120 |=> pready && pslverr;
   endproperty
   a_lower_range: assert property (p_lower_range) else $error("out-of-range lower limit accepted");

   property p_run_lower;
      @(posedge clock) disable iff (sys_rst)
      s_ff.run && !jog_active && jumped <= s_ff.lower && s_ff.lower <= s_ff.upper
         |=> target_freq == $past(s_ff.lower);
   endproperty
   a_run_lower: assert property (p_run_lower) else $error("run alone did not hold lower limit");

   property p_jog_pref;
      @(posedge clock) disable iff (sys_rst)
      jog_active && s_ff.jog <= s_ff.lower && s_ff.jog <= s_ff.upper && jumped == s_ff.jog
         |=> target_freq == $past(s_ff.jog);
   endproperty
   a_jog_pref: assert property (p_jog_pref) else $error("jog below lower limit not used");

   // First band has priority, so its A point is the expected target
   property p_band_jump;
      @(posedge clock) disable iff (sys_rst)
      s_ff.run && !jog_active && s_ff.band[0] != `CODE_OFF && s_ff.band[1] != `CODE_OFF
         && s_ff.band[0] >= s_ff.lower && s_ff.band[0] <= s_ff.upper
         && ((s_ff.freq_cmd >= s_ff.band[0] && s_ff.freq_cmd <= s_ff.band[1])
         || (s_ff.freq_cmd >= s_ff.band[1] && s_ff.freq_cmd <= s_ff.band[0]))
         |=> target_freq == $past(s_ff.band[0]);
   endproperty
   a_band_jump: assert property (p_band_jump) else $error("command in band not moved to A point");

   property p_volt_base;
      @(posedge clock) disable iff (sys_rst)
      !s_ff.vec_mode && !s_ff.rt && s_ff.base_v <= `V_1000 && s_ff.base_v < supply_voltage
         && running_freq >= s_ff.base_f |=> output_voltage == $past(s_ff.base_v);
   endproperty
   a_volt_base: assert property (p_volt_base) else $error("voltage above base not at setting");

   property p_vec_knee;
      @(posedge clock) disable iff (sys_rst)
      s_ff.vec_mode && s_ff.accel_pat == `ACC_S_A |=> s_curve_knee == $past(s_ff.mot_f);
   endproperty
   a_vec_knee: assert property (p_vec_knee) else $error("vector mode knee not at rated frequency");

   property p_rt_idle;
      @(posedge clock) disable iff (sys_rst)
      input_terminals == 7'h00 |=> !second_function_active;
   endproperty
   a_rt_idle: assert property (p_rt_idle) else $error("second function without any terminal");
endmodule

// [bench/cmd_source.sv]
`timescale 1ns/1ps
// Drive ramp: running frequency walks toward the target in fixed steps
module cmd_source #(
   parameter logic [15:0] STEP = 16'h000a
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] target_freq,
   output logic [15:0] running_freq
);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         running_freq <= 16'h0000;
      end else if (running_freq + STEP <= target_freq) begin
         running_freq <= running_freq + STEP;
      end else if (running_freq >= target_freq + STEP) begin
         running_freq <= running_freq - STEP;
      end else begin
         running_freq <= target_freq;
      end
   end
endmodule

// [bench/frequency_limit_vf_pattern_tb.sv]
`timescale 1ns/1ps
`include "fl_regs.svh"
module frequency_limit_vf_pattern_tb;
   logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, jog_active, second_function_active;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0] input_terminals;
   logic [15:0] running_freq, supply_voltage, target_freq, output_voltage, s_curve_knee;
   int miscompares = 0;
   int total_checks = 0;
   logic [7:0] ra [7] = '{`A_UPPER, `A_LOWER, `A_HS_UPPER, `A_BAND0, `A_BASE_F, `A_BASE_V, `A_BASE_F2};
   logic [15:0] rv [7] = '{`F_120, 16'h0000, `F_120, `CODE_OFF, `F_50, `CODE_95PCT, `CODE_OFF};

   freq_limit_vf dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_terminals(input_terminals), .jog_active(jog_active), .running_freq(running_freq),
      .supply_voltage(supply_voltage), .target_freq(target_freq), .output_voltage(output_voltage),
      .s_curve_knee(s_curve_knee), .second_function_active(second_function_active));

   cmd_source ramp (.clock(clock), .sys_rst(sys_rst), .target_freq(target_freq), .running_freq(running_freq));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; answer taken at the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic e);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         print_verdict();
      end
      rdat = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic ee);
      logic e;
      apb(1'b1, a, d, e);
      chk(32'(e), 32'(ee));
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic e;
      apb(1'b0, a, 16'h0000, e);
      chk(rdat, {16'h0000, exp});
   endtask

   // Lets outputs and the ramp come to rest before anything is judged
   task automatic settle();
      int n;
      n = 0;
      repeat (2) @(posedge clock);
      while (running_freq !== target_freq && n < 1000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 1000) begin
         miscompares++;
         print_verdict();
      end
      repeat (3) @(posedge clock);
   endtask

   task automatic test_reset();
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], rv[i]);
      end
      $display("test reset done");
   endtask

   task automatic test_upper();
      wr(`A_CTRL, 16'h0001, 1'b0);
      wr(`A_FCMD, 16'h05dc, 1'b0);
      settle();
      chk(32'(target_freq), 32'(`F_120));
      wr(`A_UPPER, 16'h04b1, 1'b1);
      wr(`A_HS_UPPER, 16'h04af, 1'b1);
      wr(`A_HS_UPPER, 16'h0fa1, 1'b1);
      wr(`A_HS_UPPER, 16'h05dc, 1'b0);
      rd(`A_UPPER, 16'h05dc);
      settle();
      chk(32'(target_freq), 32'h000005dc);
      wr(`A_TARGET, 16'h0001, 1'b1);
      wr(8'h5c, 16'h0001, 1'b1);
      wr(8'h02, 16'h0001, 1'b1);
      $display("test upper done");
   endtask

   task automatic test_lower();
      wr(`A_LOWER, 16'h04b1, 1'b1);
      wr(`A_LOWER, 16'h012c, 1'b0);
      wr(`A_FCMD, 16'h0064, 1'b0);
      settle();
      chk(32'(target_freq), 32'h0000012c);
      wr(`A_FCMD, 16'h0000, 1'b0);
      settle();
      chk(32'(target_freq), 32'h0000012c);
      wr(`A_JOG, 16'h00c8, 1'b0);
      jog_active <= 1'b1;
      settle();
      chk(32'(target_freq), 32'h000000c8);
      jog_active <= 1'b0;
      wr(`A_LOWER, 16'h0000, 1'b0);
      $display("test lower done");
   endtask

   task automatic test_bands();
      wr(`A_BAND0, 16'h0258, 1'b0);
      wr(`A_BAND0 + 8'h04, 16'h02bc, 1'b0);
      wr(`A_FCMD, 16'h028a, 1'b0);
      settle();
      chk(32'(target_freq), 32'h00000258);
      wr(`A_BAND0, 16'h02bc, 1'b0);
      wr(`A_BAND0 + 8'h04, 16'h0258, 1'b0);
      settle();
      chk(32'(target_freq), 32'h000002bc);
      wr(`A_LOWER, 16'h02c1, 1'b0);
      settle();
      chk(32'(target_freq), 32'h000002c1);
      wr(`A_LOWER, 16'h0000, 1'b0);
      wr(`A_BAND0, 16'h0fa1, 1'b1);
      wr(`A_UGRS, 16'h0001, 1'b0);
      wr(`A_BAND0, 16'h0258, 1'b1);
      rd(`A_BAND0, 16'h0000);
      wr(`A_UGRS, 16'h0000, 1'b0);
      wr(`A_BAND0, `CODE_OFF, 1'b0);
      settle();
      chk(32'(target_freq), 32'h0000028a);
      $display("test bands done");
   endtask

   task automatic test_vf();
      wr(`A_FCMD, 16'h00fa, 1'b0);
      wr(`A_BASE_V, `CODE_OFF, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h000000c8);
      wr(`A_CTRL, 16'h0011, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h00000064);
      wr(`A_CTRL, 16'h0001, 1'b0);
      wr(`A_FCMD, `F_50, 1'b0);
      wr(`A_BASE_V, `CODE_95PCT, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h0000017c);
      wr(`A_BASE_V, 16'h00c8, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h000000c8);
      wr(`A_BASE_V, `V_1000, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h00000190);
      wr(`A_BASE_V, 16'h03e9, 1'b1);
      wr(`A_BASE_V, `CODE_OFF, 1'b0);
      wr(`A_BASE_F2, 16'h03e8, 1'b0);
      input_terminals <= 7'h01;
      settle();
      chk(32'(second_function_active), 32'h0);
      chk(32'(output_voltage), 32'h00000190);
      wr(`A_TERM, 16'h0003, 1'b0);
      settle();
      chk(32'(second_function_active), 32'h1);
      chk(32'(output_voltage), 32'h000000c8);
      wr(`A_CTRL, 16'h0005, 1'b0);
      settle();
      chk(32'(s_curve_knee), 32'h000003e8);
      input_terminals <= 7'h00;
      settle();
      chk(32'(second_function_active), 32'h0);
      chk(32'(s_curve_knee), 32'(`F_50));
      wr(`A_MOT_F, 16'h03e8, 1'b0);
      wr(`A_MOT_V, 16'h012c, 1'b0);
      wr(`A_CTRL, 16'h0007, 1'b0);
      settle();
      chk(32'(output_voltage), 32'h00000096);
      chk(32'(s_curve_knee), 32'h000003e8);
      $display("test vf done");
   endtask

   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      input_terminals = 7'h00;
      jog_active = 1'b0;
      supply_voltage = 16'h0190;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      test_reset();
      test_upper();
      test_lower();
      test_bands();
      test_vf();
      print_verdict();
   end
endmodule
